// file: rtl/channel_packet_pkg.sv
package channel_packet_pkg;

  // Framing bytes and field identifiers
  localparam logic [7:0]  START_BYTE       = 8'h61;
  localparam logic [7:0]  TYPE_CHANNEL     = 8'h01;
  localparam logic [7:0]  FID_CODED_BITS   = 8'h01;
  localparam logic [7:0]  FID_MODE         = 8'h02;
  localparam logic [7:0]  FID_SAMPLES      = 8'h03;
  localparam logic [7:0]  FID_CODEC_SELECT = 8'h40;

  // Argument byte counts per field
  localparam logic [1:0]  ARGS_ONE         = 2'h1;
  localparam logic [1:0]  ARGS_TWO         = 2'h2;

  // Values assumed when a field is absent
  localparam logic [7:0]  DEFAULT_CHANNEL  = 8'h00;
  localparam logic [7:0]  DEFAULT_SAMPLES  = 8'hA0;
  localparam logic [15:0] DEFAULT_MODE     = 16'h0000;

  // Coded bits pack eight to a byte
  localparam logic [7:0]  FULL_MASK        = 8'hFF;
  localparam logic [5:0]  LAST_DATA_BYTE   = 6'h01;

  // Rate table span
  localparam logic [5:0]  RATE_INDEX_MAX   = 6'h3D;

  // Algorithmic delays and the decoder delay in cycles
  localparam int          CLOCK_HZ         = 25_000_000;
  localparam int          ENC_DELAY_MS     = 58;
  localparam int          DEC_DELAY_MS     = 35;
  localparam int          TOTAL_DELAY_MS   = 62;
  localparam int          DEC_DELAY_CYC    = DEC_DELAY_MS * (CLOCK_HZ / 1000);
  localparam int          TIMER_W          = 20;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_stream_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } coded_bits_t;

  typedef struct packed {
    logic        valid;
    logic        has_bits;
    logic [7:0]  channel;
    logic [7:0]  bit_count;
    logic [7:0]  samples;
    logic [15:0] mode;
  } frame_t;

  typedef struct packed {
    logic        known;
    logic [15:0] total;
    logic [15:0] speech;
    logic [15:0] fec;
  } rate_t;

  typedef enum logic [7:0] {
    ST_HUNT   = 8'h01,
    ST_LEN_HI = 8'h02,
    ST_LEN_LO = 8'h04,
    ST_TYPE   = 8'h08,
    ST_FIELD  = 8'h10,
    ST_ARG    = 8'h20,
    ST_DATA   = 8'h40,
    ST_SKIP   = 8'h80
  } parse_state_t;

endpackage

// file: rtl/rate_index_rom.sv
`timescale 1ns/10ps
module rate_index_rom (
  input  wire                          i_clock,
  input  wire                          i_srst,
  input  wire                          i_clk_en,
  input  wire [5:0]                    i_index,
  output channel_packet_pkg::rate_t    o_rate
);

  channel_packet_pkg::rate_t rate_d;
  channel_packet_pkg::rate_t rate_q;

  function automatic channel_packet_pkg::rate_t mk(input int t,
                                                   input int s,
                                                   input int f);
    mk.known  = 1'b1;
    mk.total  = 16'(t);
    mk.speech = 16'(s);
    mk.fec    = 16'(f);
  endfunction

  // Total, speech and correction rates in bps per index
  always_comb begin
    rate_d = '0;
    case (i_index)
      6'h00: rate_d = mk(2400, 2400, 0);
      6'h01: rate_d = mk(3600, 3600, 0);
      6'h02: rate_d = mk(4800, 3600, 1200);
      6'h03: rate_d = mk(4800, 4800, 0);
      6'h04: rate_d = mk(9600, 9600, 0);
      6'h05: rate_d = mk(2400, 2350, 50);
      6'h06: rate_d = mk(9600, 4850, 4750);
      6'h07: rate_d = mk(4800, 4550, 250);
      6'h08: rate_d = mk(4800, 3100, 1700);
      6'h09: rate_d = mk(7200, 4400, 2800);
      6'h0A: rate_d = mk(6400, 4150, 2250);
      6'h0B: rate_d = mk(3600, 3350, 250);
      6'h0C: rate_d = mk(8000, 7750, 250);
      6'h0D: rate_d = mk(8000, 4650, 3350);
      6'h0E: rate_d = mk(4000, 3750, 250);
      6'h0F: rate_d = mk(4000, 4000, 0);
      6'h10: rate_d = mk(3600, 3600, 0);
      6'h11: rate_d = mk(4000, 4000, 0);
      6'h12: rate_d = mk(4800, 4800, 0);
      6'h13: rate_d = mk(6400, 6400, 0);
      6'h14: rate_d = mk(8000, 8000, 0);
      6'h15: rate_d = mk(9600, 9600, 0);
      6'h16: rate_d = mk(4000, 2400, 1600);
      6'h17: rate_d = mk(4800, 3600, 1200);
      6'h18: rate_d = mk(4800, 4000, 800);
      6'h19: rate_d = mk(4800, 2400, 2400);
      6'h1A: rate_d = mk(6400, 4000, 2400);
      6'h1B: rate_d = mk(7200, 4400, 2800);
      6'h1C: rate_d = mk(8000, 4000, 4000);
      6'h1D: rate_d = mk(9600, 2400, 7200);
      6'h1E: rate_d = mk(9600, 3600, 6000);
      6'h1F: rate_d = mk(2000, 2000, 0);
      6'h20: rate_d = mk(6400, 3600, 2800);
      6'h21: rate_d = mk(3600, 2450, 1150);
      6'h22: rate_d = mk(2450, 2450, 0);
      6'h23: rate_d = mk(3400, 2250, 1150);
      6'h24: rate_d = mk(2250, 2250, 0);
      6'h25: rate_d = mk(2400, 2400, 0);
      6'h26: rate_d = mk(3000, 3000, 0);
      6'h27: rate_d = mk(3600, 3600, 0);
      6'h28: rate_d = mk(4000, 4000, 0);
      6'h29: rate_d = mk(4400, 4400, 0);
      6'h2A: rate_d = mk(4800, 4800, 0);
      6'h2B: rate_d = mk(6400, 6400, 0);
      6'h2C: rate_d = mk(7200, 7200, 0);
      6'h2D: rate_d = mk(8000, 8000, 0);
      6'h2E: rate_d = mk(9600, 9600, 0);
      6'h2F: rate_d = mk(2700, 2450, 250);
      6'h30: rate_d = mk(3600, 3350, 250);
      6'h31: rate_d = mk(4000, 3750, 250);
      6'h32: rate_d = mk(4800, 4550, 250);
      6'h33: rate_d = mk(4400, 2450, 1950);
      6'h34: rate_d = mk(4800, 2450, 2350);
      6'h35: rate_d = mk(6000, 2450, 3550);
      6'h36: rate_d = mk(7200, 2450, 4750);
      6'h37: rate_d = mk(4000, 2600, 1400);
      6'h38: rate_d = mk(4800, 3600, 1200);
      6'h39: rate_d = mk(4800, 4000, 800);
      6'h3A: rate_d = mk(6400, 4000, 2400);
      6'h3B: rate_d = mk(7200, 4400, 2800);
      6'h3C: rate_d = mk(8000, 4000, 4000);
      6'h3D: rate_d = mk(9600, 3600, 6000);
      default: rate_d = '0; // Indices above the table read as unknown
    endcase
  end

  // Registered read port
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rate_q <= '0;
    end else if (i_clk_en) begin
      rate_q <= rate_d;
    end
  end

  assign o_rate = rate_q;

endmodule

// file: rtl/channel_packet_parser.sv
`timescale 1ns/10ps
module channel_packet_parser #(
  parameter int unsigned DECODE_CYCLES = channel_packet_pkg::DEC_DELAY_CYC
) (
  input  wire                                i_clock,
  input  wire                                i_srst,
  input  wire                                i_clk_en,
  input  channel_packet_pkg::byte_stream_t   i_rx,
  output logic                               o_rx_ready,
  output channel_packet_pkg::coded_bits_t    o_bits,
  output channel_packet_pkg::frame_t         o_frame,
  output logic                               o_pkt_error,
  output logic                               o_frame_due,
  input  wire [5:0]                          i_rate_index,
  output channel_packet_pkg::rate_t          o_rate
);

  channel_packet_pkg::parse_state_t state_q;
  channel_packet_pkg::parse_state_t state_d;
  logic [15:0]                      rem_q;
  logic [15:0]                      rem_d;
  logic [7:0]                       fid_q;
  logic [7:0]                       fid_d;
  logic [1:0]                       argc_q;
  logic [1:0]                       argc_d;
  logic [5:0]                       nbytes_q;
  logic [5:0]                       nbytes_d;
  logic [2:0]                       tail_q;
  logic [2:0]                       tail_d;
  logic [7:0]                       chan_q;
  logic [7:0]                       chan_d;
  logic [7:0]                       samp_q;
  logic [7:0]                       samp_d;
  logic [15:0]                      mode_q;
  logic [15:0]                      mode_d;
  logic [7:0]                       nbits_q;
  logic [7:0]                       nbits_d;
  logic                             has_bits_q;
  logic                             has_bits_d;
  channel_packet_pkg::coded_bits_t  bits_q;
  channel_packet_pkg::coded_bits_t  bits_d;
  channel_packet_pkg::frame_t       frame_q;
  channel_packet_pkg::frame_t       frame_d;
  logic                             err_q;
  logic                             err_d;
  logic [19:0]                      timer_q;
  logic [19:0]                      timer_d;
  logic                             run_q;
  logic                             run_d;
  logic                             due_q;
  logic                             due_d;
  logic                             take;
  logic                             last;
  logic [15:0]                      body;
  logic [7:0]                       byte_in;

  // Every byte is taken at once; clock enable is the only stall
  assign o_rx_ready = i_clk_en;
  assign take       = i_clk_en & i_rx.valid;
  assign byte_in    = i_rx.data;
  assign body       = rem_q - 16'h0001;
  assign last       = (rem_q == 16'h0001);

  // Keep only the upper tail bits of a partial final byte
  function automatic logic [7:0] tail_mask(input logic [2:0] t);
    if (t == 3'h0) begin
      tail_mask = channel_packet_pkg::FULL_MASK;
    end else begin
      tail_mask = ~(channel_packet_pkg::FULL_MASK >> t);
    end
  endfunction

  // Parser next state
  always_comb begin
    logic fdone;
    logic ferr;
    fdone      = 1'b0;
    ferr       = 1'b0;
    state_d    = state_q;
    rem_d      = rem_q;
    fid_d      = fid_q;
    argc_d     = argc_q;
    nbytes_d   = nbytes_q;
    tail_d     = tail_q;
    chan_d     = chan_q;
    samp_d     = samp_q;
    mode_d     = mode_q;
    nbits_d    = nbits_q;
    has_bits_d = has_bits_q;
    bits_d     = '0;
    frame_d    = frame_q;
    frame_d.valid = 1'b0;
    err_d      = 1'b0;
    if (take) begin
      unique case (state_q)
        channel_packet_pkg::ST_HUNT: begin
          // Anything but the start byte is dropped while hunting
          if (byte_in == channel_packet_pkg::START_BYTE) begin
            state_d = channel_packet_pkg::ST_LEN_HI;
          end
        end
        channel_packet_pkg::ST_LEN_HI: begin
          rem_d[15:8] = byte_in;
          state_d     = channel_packet_pkg::ST_LEN_LO;
        end
        channel_packet_pkg::ST_LEN_LO: begin
          rem_d[7:0] = byte_in;
          state_d    = channel_packet_pkg::ST_TYPE;
        end
        channel_packet_pkg::ST_TYPE: begin
          // Type byte is outside the length count
          chan_d     = channel_packet_pkg::DEFAULT_CHANNEL;
          samp_d     = channel_packet_pkg::DEFAULT_SAMPLES;
          mode_d     = channel_packet_pkg::DEFAULT_MODE;
          nbits_d    = 8'h00;
          has_bits_d = 1'b0;
          if (byte_in == channel_packet_pkg::TYPE_CHANNEL) begin
            if (rem_q == 16'h0000) begin
              frame_d       = '{1'b1, 1'b0,
                                channel_packet_pkg::DEFAULT_CHANNEL, 8'h00,
                                channel_packet_pkg::DEFAULT_SAMPLES,
                                channel_packet_pkg::DEFAULT_MODE};
              state_d       = channel_packet_pkg::ST_HUNT;
            end else begin
              state_d = channel_packet_pkg::ST_FIELD;
            end
          end else if (rem_q == 16'h0000) begin
            state_d = channel_packet_pkg::ST_HUNT;
          end else begin
            state_d = channel_packet_pkg::ST_SKIP; // Other types pass by
          end
        end
        channel_packet_pkg::ST_FIELD: begin
          // Identifier-led items in arrival order
          rem_d   = body;
          fid_d   = byte_in;
          state_d = channel_packet_pkg::ST_ARG;
          unique case (byte_in)
            channel_packet_pkg::FID_CODED_BITS: begin
              argc_d = channel_packet_pkg::ARGS_ONE;
              ferr   = has_bits_q; // One coded frame per packet
            end
            channel_packet_pkg::FID_CODEC_SELECT: begin
              argc_d = channel_packet_pkg::ARGS_ONE;
            end
            channel_packet_pkg::FID_SAMPLES: begin
              argc_d = channel_packet_pkg::ARGS_ONE;
            end
            channel_packet_pkg::FID_MODE: begin
              argc_d = channel_packet_pkg::ARGS_TWO;
            end
            default: begin
              ferr = 1'b1; // Unknown item cannot be sized
            end
          endcase
          if (last) begin
            ferr = 1'b1; // Length ends inside the item
          end
        end
        channel_packet_pkg::ST_ARG: begin
          rem_d  = body;
          argc_d = argc_q - 2'h1;
          unique case (fid_q)
            channel_packet_pkg::FID_CODED_BITS: begin
              nbits_d    = byte_in;
              has_bits_d = 1'b1;
              tail_d     = byte_in[2:0];
              nbytes_d   = {1'b0, byte_in[7:3]} +
                           {5'h00, |byte_in[2:0]};
              if (byte_in == 8'h00) begin
                fdone = 1'b1;
              end else if (last) begin
                ferr = 1'b1;
              end else begin
                state_d = channel_packet_pkg::ST_DATA;
              end
            end
            channel_packet_pkg::FID_CODEC_SELECT: begin
              chan_d = byte_in;
              fdone  = 1'b1;
            end
            channel_packet_pkg::FID_SAMPLES: begin
              samp_d = byte_in;
              fdone  = 1'b1;
            end
            default: begin
              // Mode value arrives high byte first
              if (argc_q == channel_packet_pkg::ARGS_TWO) begin
                mode_d[15:8] = byte_in;
                ferr         = last;
              end else begin
                mode_d[7:0] = byte_in;
                fdone       = 1'b1;
              end
            end
          endcase
        end
        channel_packet_pkg::ST_DATA: begin
          // Arrival order kept: first byte holds the top bits
          rem_d       = body;
          nbytes_d    = nbytes_q - 6'h01;
          bits_d.valid = 1'b1;
          if (nbytes_q == channel_packet_pkg::LAST_DATA_BYTE) begin
            bits_d.last = 1'b1;
            bits_d.data = byte_in & tail_mask(tail_q);
            fdone       = 1'b1;
          end else begin
            bits_d.data = byte_in;
            ferr        = last;
          end
        end
        channel_packet_pkg::ST_SKIP: begin
          rem_d = body;
          if (last) begin
            state_d = channel_packet_pkg::ST_HUNT;
          end
        end
      endcase
      // Item closed: commit only if the count lands exactly
      if (fdone && !ferr) begin
        if (last) begin
          frame_d = '{1'b1, has_bits_d, chan_d, nbits_d, samp_d, mode_d};
          state_d = channel_packet_pkg::ST_HUNT;
        end else begin
          state_d = channel_packet_pkg::ST_FIELD;
        end
      end
      // Bad packet: report once and drain what the length still owes
      if (ferr) begin
        err_d   = 1'b1;
        state_d = last ? channel_packet_pkg::ST_HUNT
                       : channel_packet_pkg::ST_SKIP;
      end
    end
  end

  // Parser registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_q    <= channel_packet_pkg::ST_HUNT;
      rem_q      <= 16'h0000;
      fid_q      <= 8'h00;
      argc_q     <= 2'h0;
      nbytes_q   <= 6'h00;
      tail_q     <= 3'h0;
      chan_q     <= channel_packet_pkg::DEFAULT_CHANNEL;
      samp_q     <= channel_packet_pkg::DEFAULT_SAMPLES;
      mode_q     <= channel_packet_pkg::DEFAULT_MODE;
      nbits_q    <= 8'h00;
      has_bits_q <= 1'b0;
      bits_q     <= '0;
      frame_q    <= '0;
      err_q      <= 1'b0;
    end else if (i_clk_en) begin
      state_q    <= state_d;
      rem_q      <= rem_d;
      fid_q      <= fid_d;
      argc_q     <= argc_d;
      nbytes_q   <= nbytes_d;
      tail_q     <= tail_d;
      chan_q     <= chan_d;
      samp_q     <= samp_d;
      mode_q     <= mode_d;
      nbits_q    <= nbits_d;
      has_bits_q <= has_bits_d;
      bits_q     <= bits_d;
      frame_q    <= frame_d;
      err_q      <= err_d;
    end
  end

  // Decoder delay timer; a new frame restarts it, a late one supersedes
  always_comb begin
    timer_d = timer_q;
    run_d   = run_q;
    due_d   = 1'b0;
    if (frame_d.valid && take) begin
      timer_d = 20'h00000;
      run_d   = 1'b1;
    end else if (run_q) begin
      if (timer_q == 20'(DECODE_CYCLES - 1)) begin
        run_d = 1'b0;
        due_d = 1'b1;
      end else begin
        timer_d = timer_q + 20'h00001;
      end
    end
  end

  // Timer registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      timer_q <= 20'h00000;
      run_q   <= 1'b0;
      due_q   <= 1'b0;
    end else if (i_clk_en) begin
      timer_q <= timer_d;
      run_q   <= run_d;
      due_q   <= due_d;
    end
  end

  // Rate lookup, one cycle of read latency
  rate_index_rom u_rate_rom (
    .i_clock  (i_clock),
    .i_srst   (i_srst),
    .i_clk_en (i_clk_en),
    .i_index  (i_rate_index),
    .o_rate   (o_rate)
  );

  assign o_bits      = bits_q;
  assign o_frame     = frame_q;
  assign o_pkt_error = err_q;
  assign o_frame_due = due_q;

endmodule

// file: tb/channel_packet_checker.sv
`timescale 1ns/10ps
module channel_packet_checker #(
  parameter int unsigned DECODE_CYCLES = channel_packet_pkg::DEC_DELAY_CYC
) (
  input wire                               i_clock,
  input wire                               i_srst,
  input wire                               i_clk_en,
  input channel_packet_pkg::byte_stream_t  i_rx,
  input logic                              o_rx_ready,
  input channel_packet_pkg::coded_bits_t   o_bits,
  input channel_packet_pkg::frame_t        o_frame,
  input logic                              o_pkt_error,
  input logic                              o_frame_due,
  input wire [5:0]                         i_rate_index,
  input channel_packet_pkg::rate_t         o_rate
);
  logic [31:0] due_cnt_q;
  logic [31:0] due_cnt_d;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  // Enabled cycles since the last commit; frozen cycles do not count
  always_comb begin
    due_cnt_d = due_cnt_q;
    if (o_frame.valid) begin
      due_cnt_d = 32'h0000_0001;
    end else if (i_clk_en && due_cnt_q != 32'h0000_0000) begin
      due_cnt_d = due_cnt_q + 32'h0000_0001;
    end
  end

  // Register the count
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      due_cnt_q <= 32'h0000_0000;
    end else begin
      due_cnt_q <= due_cnt_d;
    end
  end

  property p_rate_known;
    i_clk_en && i_rate_index == 6'h21 |=> o_rate.known && o_rate.total
      == 16'h0E10 && o_rate.speech == 16'h0992 && o_rate.fec == 16'h047E;
  endproperty
  a_rate_known: assert property (p_rate_known)
    else $error("rate row lookup wrong");

  property p_rate_unknown;
    i_clk_en && i_rate_index > 6'h3D |=> !o_rate.known && o_rate.total
      == 16'h0000;
  endproperty
  a_rate_unknown: assert property (p_rate_unknown)
    else $error("rate beyond table not flagged");

  property p_due_time;
    o_frame_due |-> due_cnt_q == DECODE_CYCLES;
  endproperty
  a_due_time: assert property (p_due_time)
    else $error("decode due pulse at wrong time");

  property p_frame_cause;
    o_frame.valid && $past(i_clk_en) |-> $past(i_rx.valid);
  endproperty
  a_frame_cause: assert property (p_frame_cause)
    else $error("frame commit without a byte taken");

  property p_bits_cause;
    o_bits.valid && $past(i_clk_en) |-> $past(i_rx.valid);
  endproperty
  a_bits_cause: assert property (p_bits_cause)
    else $error("payload byte without a byte taken");

  property p_bits_order;
    o_bits.valid && !o_bits.last && $past(i_clk_en)
      |-> o_bits.data == $past(i_rx.data);
  endproperty
  a_bits_order: assert property (p_bits_order)
    else $error("payload byte altered or reordered");

  property p_error_no_frame;
    o_pkt_error |-> (!o_frame.valid) [*2];
  endproperty
  a_error_no_frame: assert property (p_error_no_frame)
    else $error("frame released with a bad packet");

  property p_reset_quiet;
    $past(i_srst) |-> !o_frame.valid && !o_bits.valid && !o_pkt_error
      && !o_frame_due;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output pulse right after reset");

  c_frame: cover property (o_frame.valid);
  c_error: cover property (o_pkt_error);
  c_due: cover property (o_frame_due);
endmodule

bind channel_packet_parser channel_packet_checker #(
  .DECODE_CYCLES(DECODE_CYCLES)
) u_channel_packet_checker (
  .i_clock     (i_clock),
  .i_srst      (i_srst),
  .i_clk_en    (i_clk_en),
  .i_rx        (i_rx),
  .o_rx_ready  (o_rx_ready),
  .o_bits      (o_bits),
  .o_frame     (o_frame),
  .o_pkt_error (o_pkt_error),
  .o_frame_due (o_frame_due),
  .i_rate_index(i_rate_index),
  .o_rate      (o_rate)
);

// file: tb/packet_host.sv
`timescale 1ns/10ps
module packet_host (
  input wire                                i_clock,
  input wire                                i_ready,
  output channel_packet_pkg::byte_stream_t  o_rx
);
  // Idle line carries no stale byte
  initial begin
    o_rx = 9'h000;
  end

  // One byte, held until the parser is ready at an edge
  task automatic put(input logic [7:0] b);
    o_rx.valid = 1'b1;
    o_rx.data = b;
    do @(posedge i_clock); while (i_ready !== 1'b1);
    #1;
  endtask

  // Release the line; inverted data so nothing stale looks valid
  task automatic idle();
    o_rx.valid = 1'b0;
    o_rx.data = ~o_rx.data;
  endtask

  // Header then body; no gap so packets may run back to back
  task automatic send_packet(input logic [7:0] ty, input logic [15:0] len,
                             input logic [7:0] q[$]);
    put(8'h61);
    put(len[15:8]);
    put(len[7:0]);
    put(ty);
    foreach (q[i]) begin
      put(q[i]);
    end
  endtask
endmodule

// file: tb/channel_packet_parser_tb.sv
`timescale 1ns/10ps
module channel_packet_parser_tb;
  localparam int unsigned DECODE_N = 20;
  typedef struct packed {
    logic [5:0]  idx;
    logic [48:0] rate;
  } rate_row_t;
  rate_row_t rows [7] = '{
    {6'h00, 1'h1, 16'h0960, 16'h0960, 16'h0000},
    {6'h15, 1'h1, 16'h2580, 16'h2580, 16'h0000},
    {6'h16, 1'h1, 16'h0FA0, 16'h0960, 16'h0640},
    {6'h21, 1'h1, 16'h0E10, 16'h0992, 16'h047E},
    {6'h2F, 1'h1, 16'h0A8C, 16'h0992, 16'h00FA},
    {6'h3D, 1'h1, 16'h2580, 16'h0E10, 16'h1770},
    {6'h3E, 1'h0, 16'h0000, 16'h0000, 16'h0000}};
  logic                              i_clock = 1'b0;
  logic                              i_srst = 1'b1;
  logic                              i_clk_en = 1'b1;
  logic [5:0]                        i_rate_index = 6'h00;
  channel_packet_pkg::byte_stream_t  rx;
  channel_packet_pkg::coded_bits_t   bits;
  channel_packet_pkg::frame_t        frame;
  channel_packet_pkg::rate_t         rate;
  channel_packet_pkg::coded_bits_t   bits_q[$];
  channel_packet_pkg::frame_t        frm = '0;
  logic                              rx_ready;
  logic                              pkt_error;
  logic                              frame_due;
  logic [7:0]                        body[$];
  int                                err_count = 0;
  int                                check_count = 0;
  int                                n_frame = 0;
  int                                n_err = 0;
  int                                n_due = 0;

  // Clock at 25 MHz
  always #20 i_clock = ~i_clock;

  channel_packet_parser #(.DECODE_CYCLES(DECODE_N)) u_channel_packet_parser (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_clk_en    (i_clk_en),
    .i_rx        (rx),
    .o_rx_ready  (rx_ready),
    .o_bits      (bits),
    .o_frame     (frame),
    .o_pkt_error (pkt_error),
    .o_frame_due (frame_due),
    .i_rate_index(i_rate_index),
    .o_rate      (rate)
  );

  packet_host u_packet_host (
    .i_clock(i_clock),
    .i_ready(rx_ready),
    .o_rx   (rx)
  );

  // Collect pulses once per enabled cycle, frozen cycles skipped
  always @(posedge i_clock) begin
    if (!i_srst && i_clk_en) begin
      if (bits.valid === 1'b1) bits_q.push_back(bits);
      if (frame.valid === 1'b1) frm = frame;
      if (frame.valid === 1'b1) n_frame++;
      if (pkt_error === 1'b1) n_err++;
      if (frame_due === 1'b1) n_due++;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog, generous against a run of some 115 cycles
  initial begin
    #120000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    check(frame, 64'h0);
    check(rx_ready, 64'h1);
    // Rate table rows
    foreach (rows[i]) begin
      i_rate_index = rows[i].idx;
      @(posedge i_clock);
      #1;
      check(rate, rows[i].rate);
    end
    // Plain packet after a stray byte, stalled by clock enable
    body = {8'h01, 8'h50};
    for (int i = 0; i < 10; i++) body.push_back(8'(8'h11 * i));
    fork
      begin
        u_packet_host.put(8'h55);
        u_packet_host.send_packet(8'h01, 16'h000C, body);
        u_packet_host.idle();
      end
      begin
        repeat (9) @(posedge i_clock);
        #1;
        i_clk_en = 1'b0;
        @(posedge i_clock);
        #1;
        i_clk_en = 1'b1;
      end
    join
    repeat (3) @(posedge i_clock);
    #1;
    check(bits_q.size(), 64'd10);
    foreach (bits_q[i]) begin
      check(bits_q[i].data, 8'(8'h11 * i));
      check(bits_q[i].last, (i == 9));
    end
    check(frm, {2'h3, 8'h00, 8'h50, 8'hA0, 16'h0000});
    // Channel select, partial last byte, sample count and mode
    bits_q.delete();
    body = {8'h40, 8'h05, 8'h01, 8'h3B};
    repeat (8) body.push_back(8'hFF);
    body = {body, 8'h03, 8'hA1, 8'h02, 8'h12, 8'h34};
    u_packet_host.send_packet(8'h01, 16'h0011, body);
    u_packet_host.idle();
    repeat (3) @(posedge i_clock);
    #1;
    check(bits_q.size(), 64'd8);
    check(bits_q[7], {2'h3, 8'hE0});
    check(frm, {2'h3, 8'h05, 8'h3B, 8'hA1, 16'h1234});
    repeat (DECODE_N) @(posedge i_clock);
    #1;
    check(n_due, 64'd2);
    // Reset inside a header; a parser left mid-packet would skew the rest
    u_packet_host.put(8'h61);
    u_packet_host.put(8'h00);
    u_packet_host.put(8'h05);
    u_packet_host.idle();
    i_srst = 1'b1;
    @(posedge i_clock);
    #1;
    i_srst = 1'b0;
    check(frame, 64'h0);
    check(pkt_error, 64'h0);
    // Short length, unknown item, foreign type, empty packet, back to back
    n_frame = 0;
    body = {8'h01, 8'h50, 8'h00};
    u_packet_host.send_packet(8'h01, 16'h0003, body);
    body = {8'h07, 8'hAA, 8'hBB};
    u_packet_host.send_packet(8'h01, 16'h0003, body);
    body = {8'h00, 8'h00};
    u_packet_host.send_packet(8'h02, 16'h0002, body);
    body.delete();
    u_packet_host.send_packet(8'h01, 16'h0000, body);
    u_packet_host.idle();
    repeat (3) @(posedge i_clock);
    #1;
    check(n_err, 64'd2);
    check(n_frame, 64'd1);
    check(frm, {2'h2, 8'h00, 8'h00, 8'hA0, 16'h0000});
    conclude();
  end
endmodule
